// File: pkg/cho_pkg.sv
package cho_pkg;

    // ----------------------------------------------------------------
    // Clock and time base
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ       = 100_000_000;
    localparam int unsigned MS_PER_S     = 1000;
    localparam int unsigned MS_CYCLES    = CLK_HZ / MS_PER_S;

    // Times in milliseconds, as printed
    localparam int unsigned DEGLITCH_SHORT_MS = 150;
    localparam int unsigned DEGLITCH_LONG_MS  = 1300;
    localparam int unsigned WDOG_44_MS        = 44 * MS_PER_S;
    localparam int unsigned WDOG_88_MS        = 88 * MS_PER_S;
    localparam int unsigned WDOG_175_MS       = 175 * MS_PER_S;

    // ----------------------------------------------------------------
    // Command codes
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_CHARGER_OPTIONS   = 8'h12;
    localparam logic [7:0] CMD_BATTERY_CURRENT   = 8'h14;
    localparam logic [7:0] CMD_CHARGE_VOLTAGE    = 8'h15;

    // ----------------------------------------------------------------
    // Charger options fields
    // ----------------------------------------------------------------
    localparam logic [15:0] OPTIONS_RESET   = 16'hF902;
    localparam int unsigned BIT_DEGLITCH    = 15;
    localparam int unsigned BIT_WDOG_HI     = 14;
    localparam int unsigned BIT_WDOG_LO     = 13;
    localparam int unsigned BIT_DEPL_HI     = 12;
    localparam int unsigned BIT_DEPL_LO     = 11;
    localparam int unsigned BIT_FREQ_UP     = 10;
    localparam int unsigned BIT_FREQ_EN     = 9;
    localparam int unsigned BIT_HS_FAULT    = 8;
    localparam int unsigned BIT_LS_FAULT    = 7;
    localparam int unsigned BIT_LEARN       = 6;
    localparam int unsigned BIT_IMON_SEL    = 5;
    localparam int unsigned BIT_ADPT_IND    = 4;
    localparam int unsigned BIT_BOOST_EN    = 3;
    localparam int unsigned BIT_BOOST_IND   = 2;
    localparam int unsigned BIT_ACOC        = 1;
    localparam int unsigned BIT_INHIBIT     = 0;

    // Watchdog select codes
    localparam logic [1:0] WDOG_OFF = 2'h0;
    localparam logic [1:0] WDOG_44  = 2'h1;
    localparam logic [1:0] WDOG_88  = 2'h2;
    localparam logic [1:0] WDOG_175 = 2'h3;

    // Depletion threshold select codes (1x both give the highest)
    localparam logic [1:0] DEPL_5919 = 2'h0;
    localparam logic [1:0] DEPL_6265 = 2'h1;
    localparam logic [1:0] DEPL_7097 = 2'h2;

    // Synchroniser bit positions
    localparam int unsigned SYN_SUPPLY_OK  = 0;
    localparam int unsigned SYN_DETECT_LOW = 1;
    localparam int unsigned SYN_ADPT_PRES  = 2;
    localparam int unsigned SYN_DEPLETED   = 3;
    localparam int unsigned SYN_BOOST_DMD  = 4;
    localparam int unsigned SYN_WIDTH      = 5;

    // Word command from the serial engine
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  code;
        logic [15:0] wdata;
    } cho_cmd_t;

    typedef enum logic {
        CHO_LEARN_IDLE,
        CHO_LEARN_RUN
    } cho_learn_t;

endpackage

// File: core/cho_charger_options.sv
`timescale 1ns/1ps

// Overview of operation
// - Host writes the options word with command 0x12; applied after power-on reset.
// - First adapter insertion after reset always uses a 150ms rising deglitch.
// - Bit 15 picks 150ms or 1.3s deglitch once the adapter switch has opened.
// - Commands accepted only with supply above lockout and adapter detect above 0.6V.
// - Bits 14:13 pick watchdog off, 44s, 88s or 175s (default 175s).
// - Enabled watchdog suspends charging when no voltage/current write arrives in time.
// - A voltage or current write resumes charging after a watchdog suspension.
// - During boost an enabled watchdog always uses 175s.
// - Bits 12:11 pick depletion threshold 59.19%, 62.65% or 70.97% (default).
// - Learn cycle hitting depletion opens battery switch and closes adapter switch.
// - Boost stops when battery falls below the depletion threshold.
// - Depletion clears only after battery rises 340mV above the threshold.
// - A zero charge-voltage setting disables depletion detection.
// - Bit 10 sets frequency shift direction: 0 lowers 18%, 1 raises 18%.
// - Bit 9 enables the frequency shift; 0 keeps nominal frequency.
// - Bit 8 enables high-side short comparator at 750mV; default on.
// - Bit 7 picks low-side threshold 135mV or 230mV, also boost current limit.
// - Writing 1 to bit 6 starts learn: adapter switch off, battery switch on.
// - Learn ending at depletion restores adapter power and clears bit 6.
// - Writing 0 to bit 6 aborts learn: battery switch off, adapter switch on.
// - Bit 5 routes adapter or charge current amplifier to current monitor.
// - Bit 3 enables boost; cleared at reset.
module cho_charger_options #(
    parameter int unsigned TICK_CYCLES = cho_pkg::MS_CYCLES
) (
    input  wire logic            clk_sys,
    input  wire logic            rst_n,
    input  wire cho_pkg::cho_cmd_t cmd,
    input  wire logic            charge_voltage_zero,
    input  wire logic            supply_above_undervoltage_lockout,
    input  wire logic            adapter_detect_input,
    input  wire logic            adapter_present,
    input  wire logic            battery_depleted,
    input  wire logic            boost_demand,
    output logic                 cmd_accepted,
    output logic                 rd_valid,
    output logic [15:0]          rd_data,
    output logic                 adapter_good_indication,
    output logic                 adapter_switch,
    output logic                 battery_switch,
    output logic                 charge_suspended,
    output logic                 boost_active,
    output logic                 freq_adjust_en,
    output logic                 freq_adjust_up,
    output logic                 high_side_fault_threshold,
    output logic                 low_side_fault_threshold,
    output logic                 current_monitor_output,
    output logic [1:0]           depletion_thr_sel,
    output logic                 depletion_detected
);

    localparam int unsigned TICK_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
    localparam int unsigned DG_W   = $clog2(cho_pkg::DEGLITCH_LONG_MS + 1);
    localparam int unsigned WD_W   = $clog2(cho_pkg::WDOG_175_MS + 1);

    localparam logic [TICK_W-1:0] TICK_LAST  = TICK_W'(TICK_CYCLES - 1);
    localparam logic [DG_W-1:0]   DG_SHORT   = DG_W'(cho_pkg::DEGLITCH_SHORT_MS);
    localparam logic [DG_W-1:0]   DG_LONG    = DG_W'(cho_pkg::DEGLITCH_LONG_MS);
    localparam logic [WD_W-1:0]   WD_44      = WD_W'(cho_pkg::WDOG_44_MS);
    localparam logic [WD_W-1:0]   WD_88      = WD_W'(cho_pkg::WDOG_88_MS);
    localparam logic [WD_W-1:0]   WD_175     = WD_W'(cho_pkg::WDOG_175_MS);

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [cho_pkg::SYN_WIDTH-1:0] async_in;
    logic [cho_pkg::SYN_WIDTH-1:0] sync_ff1;
    logic [cho_pkg::SYN_WIDTH-1:0] sync_ff2;

    assign async_in = {boost_demand, battery_depleted, adapter_present,
                       adapter_detect_input, supply_above_undervoltage_lockout};

    genvar gi;
    generate
        for (gi = 0; gi < cho_pkg::SYN_WIDTH; gi++) begin : g_sync
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    sync_ff1[gi] <= 1'b0;
                    sync_ff2[gi] <= 1'b0;
                end else begin
                    sync_ff1[gi] <= async_in[gi];
                    sync_ff2[gi] <= sync_ff1[gi];
                end
            end
        end
    endgenerate

    logic supply_ok;
    logic detect_ok;
    logic adapter_in;
    logic depleted_in;
    logic boost_dmd;

    assign supply_ok   = sync_ff2[cho_pkg::SYN_SUPPLY_OK];
    assign detect_ok   = sync_ff2[cho_pkg::SYN_DETECT_LOW];
    assign adapter_in  = sync_ff2[cho_pkg::SYN_ADPT_PRES];
    assign depleted_in = sync_ff2[cho_pkg::SYN_DEPLETED];
    assign boost_dmd   = sync_ff2[cho_pkg::SYN_BOOST_DMD];

    // ----------------------------------------------------------------
    // Command decode
    // ----------------------------------------------------------------
    function automatic logic is_write(input cho_pkg::cho_cmd_t c, input logic [7:0] code);
        return c.valid && c.write && (c.code == code);
    endfunction

    logic comm_en;
    logic opt_wr;
    logic opt_rd;
    logic wdog_kick;

    // bus gated by supply and adapter detect
    assign comm_en   = supply_ok && detect_ok;
    // options word at its command code
    assign opt_wr    = comm_en && is_write(cmd, cho_pkg::CMD_CHARGER_OPTIONS);
    assign opt_rd    = comm_en && cmd.valid && !cmd.write
                       && (cmd.code == cho_pkg::CMD_CHARGER_OPTIONS);
    assign wdog_kick = comm_en && (is_write(cmd, cho_pkg::CMD_BATTERY_CURRENT)
                                   || is_write(cmd, cho_pkg::CMD_CHARGE_VOLTAGE));

    // ----------------------------------------------------------------
    // Options register
    // ----------------------------------------------------------------
    logic [15:0]         options_reg;
    logic                learn_done;
    cho_pkg::cho_learn_t learn_reg;

    // Read-only indications are not stored, only reflected on read
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            options_reg <= cho_pkg::OPTIONS_RESET;
        end else if (opt_wr) begin
            // Host write wins over the self-clear of the learn bit
            options_reg <= cmd.wdata;
            options_reg[cho_pkg::BIT_ADPT_IND]  <= 1'b0;
            options_reg[cho_pkg::BIT_BOOST_IND] <= 1'b0;
        end else if (learn_done) begin
            options_reg[cho_pkg::BIT_LEARN] <= 1'b0;
        end
    end

    logic [15:0] read_word;
    always_comb begin
        read_word = options_reg;
        read_word[cho_pkg::BIT_ADPT_IND]  = adapter_in;
        read_word[cho_pkg::BIT_BOOST_IND] = boost_active;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_valid     <= 1'b0;
            rd_data      <= 16'h0000;
            cmd_accepted <= 1'b0;
        end else begin
            rd_valid     <= opt_rd;
            cmd_accepted <= cmd.valid && comm_en;
            if (opt_rd) begin
                rd_data <= read_word;
            end
        end
    end

    // ----------------------------------------------------------------
    // Millisecond tick
    // ----------------------------------------------------------------
    logic [TICK_W-1:0] tick_cnt;
    logic              ms_tick;

    // Long times counted in ms so counters stay narrow
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt <= '0;
            ms_tick  <= 1'b0;
        end else if (tick_cnt == TICK_LAST) begin
            tick_cnt <= '0;
            ms_tick  <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + TICK_W'(1);
            ms_tick  <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Adapter-present deglitch
    // ----------------------------------------------------------------
    logic            switch_opened_reg;
    logic [DG_W-1:0] dg_cnt;
    logic [DG_W-1:0] dg_limit;

    // short deglitch until the adapter switch has opened once
    // afterwards bit 15 picks the time
    assign dg_limit = (switch_opened_reg && options_reg[cho_pkg::BIT_DEGLITCH])
                      ? DG_LONG : DG_SHORT;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            switch_opened_reg <= 1'b0;
        end else if (adapter_switch && (!adapter_good_indication
                                        || learn_reg == cho_pkg::CHO_LEARN_RUN)) begin
            switch_opened_reg <= 1'b1;
        end
    end

    // Falling edge is immediate, only the rising edge is filtered
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dg_cnt                  <= '0;
            adapter_good_indication <= 1'b0;
        end else if (!adapter_in) begin
            dg_cnt                  <= '0;
            adapter_good_indication <= 1'b0;
        end else if (!adapter_good_indication && ms_tick) begin
            if (dg_cnt >= dg_limit - DG_W'(1)) begin
                adapter_good_indication <= 1'b1;
            end else begin
                dg_cnt <= dg_cnt + DG_W'(1);
            end
        end
    end

    // ----------------------------------------------------------------
    // Depletion detection and boost
    // ----------------------------------------------------------------
    logic depleted;

    // hysteresis lives in the comparator itself
    assign depleted = depleted_in && !charge_voltage_zero;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            depletion_detected <= 1'b0;
            boost_active       <= 1'b0;
        end else begin
            depletion_detected <= depleted;
            boost_active       <= options_reg[cho_pkg::BIT_BOOST_EN] && boost_dmd
                                  && !depleted && adapter_good_indication;
        end
    end

    // ----------------------------------------------------------------
    // Command watchdog
    // ----------------------------------------------------------------
    logic [1:0]      wdog_sel;
    logic [WD_W-1:0] wd_cnt;
    logic [WD_W-1:0] wd_limit;

    assign wdog_sel = options_reg[cho_pkg::BIT_WDOG_HI:cho_pkg::BIT_WDOG_LO];

    always_comb begin
        unique case (wdog_sel)
            cho_pkg::WDOG_44:  wd_limit = WD_44;
            cho_pkg::WDOG_88:  wd_limit = WD_88;
            cho_pkg::WDOG_175, cho_pkg::WDOG_OFF: wd_limit = WD_175;
        endcase
        if (boost_active) begin
            wd_limit = WD_175;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wd_cnt           <= '0;
            charge_suspended <= 1'b0;
        end else if (wdog_sel == cho_pkg::WDOG_OFF) begin
            wd_cnt           <= '0;
            charge_suspended <= 1'b0;
        end else if (wdog_kick) begin
            wd_cnt           <= '0;
            charge_suspended <= 1'b0;
        end else if (ms_tick && !charge_suspended) begin
            if (wd_cnt >= wd_limit - WD_W'(1)) begin
                charge_suspended <= 1'b1;
                wd_cnt           <= '0;
            end else begin
                wd_cnt <= wd_cnt + WD_W'(1);
            end
        end
    end

    // ----------------------------------------------------------------
    // Learn sequencing and power switches
    // ----------------------------------------------------------------
    logic learn_start;
    logic learn_abort;

    assign learn_start = opt_wr && cmd.wdata[cho_pkg::BIT_LEARN];
    assign learn_abort = opt_wr && !cmd.wdata[cho_pkg::BIT_LEARN];
    // end at depletion, unless the host rewrites the bit
    assign learn_done  = (learn_reg == cho_pkg::CHO_LEARN_RUN) && depleted;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            learn_reg <= cho_pkg::CHO_LEARN_IDLE;
        end else begin
            unique case (learn_reg)
                cho_pkg::CHO_LEARN_IDLE: begin
                    if (learn_start) begin
                        learn_reg <= cho_pkg::CHO_LEARN_RUN;
                    end
                end
                cho_pkg::CHO_LEARN_RUN: begin
                    if (learn_abort || (learn_done && !learn_start)) begin
                        learn_reg <= cho_pkg::CHO_LEARN_IDLE;
                    end
                end
            endcase
        end
    end

    // Break-before-make is left to the gate drivers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            adapter_switch <= 1'b0;
            battery_switch <= 1'b0;
        end else if (learn_reg == cho_pkg::CHO_LEARN_RUN && !learn_done) begin
            adapter_switch <= 1'b0;
            battery_switch <= 1'b1;
        end else begin
            // adapter feeds system while good; battery switch open unless adapter not good or boost active
            adapter_switch <= adapter_good_indication;
            battery_switch <= !adapter_good_indication || boost_active;
        end
    end

    // ----------------------------------------------------------------
    // Analog option controls
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            freq_adjust_en            <= 1'b0;
            freq_adjust_up            <= 1'b0;
            high_side_fault_threshold <= 1'b0;
            low_side_fault_threshold  <= 1'b0;
            current_monitor_output    <= 1'b0;
            depletion_thr_sel         <= cho_pkg::DEPL_5919;
        end else begin
            freq_adjust_en            <= options_reg[cho_pkg::BIT_FREQ_EN];
            freq_adjust_up            <= options_reg[cho_pkg::BIT_FREQ_UP];
            high_side_fault_threshold <= options_reg[cho_pkg::BIT_HS_FAULT];
            low_side_fault_threshold  <= options_reg[cho_pkg::BIT_LS_FAULT];
            current_monitor_output    <= options_reg[cho_pkg::BIT_IMON_SEL];
            // 1x codes both mean the highest threshold
            depletion_thr_sel         <= options_reg[cho_pkg::BIT_DEPL_HI] ? cho_pkg::DEPL_7097
                                         : {1'b0, options_reg[cho_pkg::BIT_DEPL_LO]};
        end
    end

endmodule

// File: verification/cho_host.sv
`timescale 1ns/1ps
module cho_host (
    input  wire logic        clk_sys,
    input  wire logic        cmd_accepted,
    input  wire logic [15:0] rd_data,
    output cho_pkg::cho_cmd_t cmd
);
    initial cmd = '0;
    // ------------------------------------------------------------
    // Word commands
    // ------------------------------------------------------------
    // one word per call
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                        output logic [15:0] q, output logic ok);
        @(posedge clk_sys);
        cmd <= '{valid: 1'b1, write: w, code: c, wdata: d};
        @(posedge clk_sys);
        // Released fields flip so nothing rides on stale values
        cmd <= '{valid: 1'b0, write: !w, code: ~c, wdata: ~d};
        #1;
        ok = cmd_accepted;
        q = rd_data;
    endtask
endmodule

// File: verification/cho_charger_options_checker.sv
`timescale 1ns/1ps
module cho_charger_options_checker #(
    parameter int unsigned TICK_CYCLES = cho_pkg::MS_CYCLES
) (
    input wire logic              clk_sys,
    input wire logic              rst_n,
    input wire cho_pkg::cho_cmd_t cmd,
    input wire logic              charge_voltage_zero,
    input wire logic              supply_above_undervoltage_lockout,
    input wire logic              adapter_detect_input,
    input wire logic              adapter_present,
    input wire logic              battery_depleted,
    input wire logic              boost_demand,
    input wire logic              cmd_accepted,
    input wire logic              rd_valid,
    input wire logic [15:0]       rd_data,
    input wire logic              adapter_good_indication,
    input wire logic              adapter_switch,
    input wire logic              battery_switch,
    input wire logic              charge_suspended,
    input wire logic              boost_active,
    input wire logic              freq_adjust_en,
    input wire logic              freq_adjust_up,
    input wire logic              high_side_fault_threshold,
    input wire logic              low_side_fault_threshold,
    input wire logic              current_monitor_output,
    input wire logic [1:0]        depletion_thr_sel,
    input wire logic              depletion_detected
);
    // ------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------
    // Free-running tick: two ticks of slack on lower bounds
    localparam int unsigned D_MIN = (cho_pkg::DEGLITCH_SHORT_MS - 2) * TICK_CYCLES;
    localparam int unsigned W_MIN = (cho_pkg::WDOG_44_MS - 2) * TICK_CYCLES;
    logic        qual_reg;
    int unsigned pres_reg;
    int unsigned wd_reg;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            qual_reg <= 1'b0;
            pres_reg <= 0;
            wd_reg   <= 0;
        end else begin
            qual_reg <= cmd.valid && cmd.write && (cmd.code == 8'h14 || cmd.code == 8'h15);
            pres_reg <= adapter_present ? pres_reg + 1 : 0;
            wd_reg   <= (qual_reg && cmd_accepted) ? 0 : wd_reg + 1;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence opt_wr(m);
        cmd.valid && cmd.write && cmd.code == 8'h12 && m ##1 cmd_accepted;
    endsequence

    rd_cause_a: assert property (rd_valid |->
        $past(cmd.valid && !cmd.write && cmd.code == 8'h12)) else $error("stray read");
    copy_bits_a: assert property (opt_wr(1'b1) |=>
        {freq_adjust_up, freq_adjust_en, high_side_fault_threshold, low_side_fault_threshold,
         current_monitor_output} == $past({cmd.wdata[10:7], cmd.wdata[5]}, 2))
        else $error("option copy wrong");
    depl_sel_a: assert property (opt_wr(1'b1) |=> depletion_thr_sel ==
        ($past(cmd.wdata[12], 2) ? 2'h2 : $past(cmd.wdata[12:11], 2)))
        else $error("threshold select wrong");
    learn_start_a: assert property (opt_wr(cmd.wdata[6]) |=> ##[0:2]
        (!adapter_switch && battery_switch) || depletion_detected) else $error("learn start");
    learn_abort_a: assert property (opt_wr(!cmd.wdata[6]) ##0 (battery_switch &&
        !adapter_switch) |=> ##[0:2] adapter_switch == adapter_good_indication)
        else $error("learn abort");
    learn_end_a: assert property ($rose(depletion_detected) &&
        $past(battery_switch && !adapter_switch) |-> adapter_switch == adapter_good_indication
        && !battery_switch == adapter_good_indication) else $error("learn end");
    wd_resume_a: assert property (qual_reg && cmd_accepted |=> !charge_suspended)
        else $error("no resume");
    wd_min_a: assert property ($rose(charge_suspended) |-> wd_reg >= W_MIN)
        else $error("watchdog early");
    boost_stop_a: assert property (depletion_detected |-> ##[1:3] !boost_active)
        else $error("boost kept");
    dep_mask_a: assert property (charge_voltage_zero && $past(charge_voltage_zero)
        |-> !depletion_detected) else $error("depletion unmasked");
    deg_min_a: assert property ($rose(adapter_good_indication) |-> pres_reg >= D_MIN)
        else $error("deglitch short");

    cover property (opt_wr(cmd.wdata[6]) ##3 battery_switch);
    cover property ($rose(charge_suspended));
    cover property ($rose(boost_active));
endmodule

bind cho_charger_options cho_charger_options_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.*);

// File: verification/charger_option_control_test.sv
`timescale 1ns/1ps
module charger_option_control_test;
    logic              clk_sys = 1'b0;
    logic              rst_n = 1'b0;
    logic              charge_voltage_zero = 1'b0;
    logic              supply_above_undervoltage_lockout = 1'b1;
    logic              adapter_detect_input = 1'b1;
    logic              adapter_present = 1'b1;
    logic              battery_depleted = 1'b0;
    logic              boost_demand = 1'b0;
    cho_pkg::cho_cmd_t cmd;
    logic              cmd_accepted, rd_valid, adapter_good_indication, adapter_switch;
    logic              battery_switch, charge_suspended, boost_active, freq_adjust_en;
    logic              freq_adjust_up, high_side_fault_threshold, low_side_fault_threshold;
    logic              current_monitor_output, depletion_detected, ok;
    logic [1:0]        depletion_thr_sel;
    logic [15:0]       rd_data, q;
    int                bad_count = 0;
    int                comparisons = 0;
    int                cycles = 0;
    int                n;

    // Millisecond tick shortened to one cycle
    cho_charger_options #(.TICK_CYCLES(1)) DUT (.*);
    cho_host HOST (.*);

    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    task end_sim;
        if (bad_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 60000) begin
            bad_count++;
            $display("mismatch %0t timeout", $time);
            end_sim();
        end
    end

    task chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %0t got %h want %h", $time, got, exp);
        end
    endtask

    task chkn(input int got, input int lo, input int hi);
        comparisons++;
        if (got < lo || got > hi) begin
            bad_count++;
            $display("mismatch %0t count %0d", $time, got);
        end
    endtask

    task tick(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask

    task wr(input logic [7:0] c, input logic [15:0] d);
        HOST.xfer(1'b1, c, d, q, ok);
    endtask

    task rd;
        HOST.xfer(1'b0, 8'h12, 16'h0000, q, ok);
    endtask

    task wait_ag;
        n = 0;
        while (adapter_good_indication !== 1'b1 && n < 3000) begin
            tick(1);
            n++;
        end
    endtask

    initial begin
        tick(5);
        @(posedge clk_sys);
        rst_n <= 1'b1;
        wait_ag();
        chkn(n, 140, 156);
        rd();
        chk(q, 16'hF912);
        wr(8'h12, 16'h27A0);
        tick(2);
        chk({freq_adjust_up, freq_adjust_en, high_side_fault_threshold,
             low_side_fault_threshold, current_monitor_output}, 16'h001F);
        rd();
        chk(q, 16'h27B0);
        @(posedge clk_sys);
        adapter_detect_input <= 1'b0;
        tick(4);
        wr(8'h12, 16'h0800);
        chk(ok, 1'b0);
        @(posedge clk_sys);
        adapter_detect_input <= 1'b1;
        tick(4);
        for (int i = 0; i < 4; i++) begin
            wr(8'h12, 16'(i) << 11);
            tick(2);
            chk(depletion_thr_sel, (i == 3) ? 16'h0002 : 16'(i));
        end
        for (int i = 0; i < 2; i++) begin
            wr(8'h12, i ? 16'h8000 : 16'h0000);
            @(posedge clk_sys);
            adapter_present <= 1'b0;
            tick(5);
            adapter_present <= 1'b1;
            wait_ag();
            chkn(n, i ? 1290 : 145, i ? 1310 : 158);
        end
        for (int i = 0; i < 2; i++) begin
            wr(8'h12, 16'h0040);
            tick(3);
            chk({adapter_switch, battery_switch}, 16'h0001);
            @(posedge clk_sys);
            if (i == 0)
                battery_depleted <= 1'b1;
            else
                wr(8'h12, 16'h0000);
            tick(6);
            chk({adapter_switch, battery_switch}, 16'h0002);
            rd();
            chk(q[6], 1'b0);
            battery_depleted <= 1'b0;
            tick(4);
        end
        @(posedge clk_sys);
        charge_voltage_zero <= 1'b1;
        battery_depleted <= 1'b1;
        tick(5);
        chk(depletion_detected, 1'b0);
        charge_voltage_zero <= 1'b0;
        tick(5);
        chk(depletion_detected, 1'b1);
        battery_depleted <= 1'b0;
        wr(8'h12, 16'h0008);
        boost_demand <= 1'b1;
        tick(5);
        chk(boost_active, 1'b1);
        rd();
        chk(q[2], 1'b1);
        battery_depleted <= 1'b1;
        tick(5);
        chk(boost_active, 1'b0);
        battery_depleted <= 1'b0;
        boost_demand <= 1'b0;
        wr(8'h12, 16'h2000);
        wr(8'h15, 16'h1000);
        n = 0;
        while (charge_suspended !== 1'b1 && n < 50000) begin
            tick(1);
            n++;
        end
        chkn(n, 43990, 44010);
        wr(8'h14, 16'h0080);
        tick(1);
        chk(charge_suspended, 1'b0);
        end_sim();
    end
endmodule
